// ==== verilog/dbgtr_pkg.sv ====
// constants and carrier types for the debug command tail and opcode tracking
// assumes one 10 MHz system clock shared by the core, the command decoder
// and the tracking pins
package dbgtr_pkg;
    localparam logic [15:0] DBGTR_CMD_NULL = 16'h0000;
    localparam logic [15:0] DBGTR_CMD_PRST = 16'h0400;
    localparam logic [15:0] DBGTR_CMD_CALL = 16'h0800;
    localparam logic [16:0] DBGTR_RSP_DONE = 17'h0FFFF;
    localparam logic [16:0] DBGTR_RSP_ERR  = 17'h10001;
    localparam logic [16:0] DBGTR_RSP_ILL  = 17'h1FFFF;
    localparam int          DBGTR_CLK_NS   = 100;
    localparam int          DBGTR_RST_CLKS = 512;
    localparam logic [9:0]  DBGTR_CNT_ONE  = 10'h001;
    localparam logic [9:0]  DBGTR_CNT_ZERO = 10'h000;
    localparam logic [1:0]  DBGTR_ADV_ONE  = 2'h1;
    localparam logic [1:0]  DBGTR_ADV_TWO  = 2'h2;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } dbgtr_stage_type;

    typedef struct packed {
        logic        push_req;
        logic [31:0] push_data;
        logic [31:0] push_addr;
        logic        pc_load;
        logic [31:0] pc_value;
        logic        exit_debug;
    } dbgtr_core_req_type;

    typedef enum {
        DBGTR_IDLE,
        DBGTR_PUSH,
        DBGTR_PREF,
        DBGTR_PRST,
        DBGTR_RESP
    } dbgtr_state_type;
endpackage

// ==== verilog/dbgtr_stage.sv ====
// one pipeline stage: word register with validity bit
// assumes the parent decides load and clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module dbgtr_stage
    import dbgtr_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    input  wire logic            load_i,
    input  wire logic            clear_i,
    input  wire logic [15:0]     word_i,
    output var  dbgtr_stage_type stage_o
);
    dbgtr_stage_type stage;
    dbgtr_stage_type next_stage;

    always_comb begin
        next_stage = stage;
        // a load beats a clear so a word moving in is never lost
        if (load_i) begin
            next_stage.valid = 1'b1;
            next_stage.word  = word_i;
        end else if (clear_i) begin
            next_stage.valid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage <= '0;
        end else begin
            stage <= next_stage;
        end
    end

    assign stage_o = stage;
endmodule
`default_nettype wire

// ==== verilog/dbgtr_top.sv ====
// debug command tail (patch-call, peripheral reset, null, unassigned)
// and opcode tracking outputs for fetch and pipe advance
// assumes the core gives fetch, advance and push/prefetch results in sync
// with clk_i; the serial shifter takes resp_o when resp_valid_o pulses
`timescale 1ns/1ps
`default_nettype none
module dbgtr_top
    import dbgtr_pkg::*;
#(
    parameter int RST_CLKS = DBGTR_RST_CLKS
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               cmd_valid_i,
    input  wire logic [15:0]        cmd_word_i,
    input  wire logic [31:0]        cmd_operand_i,
    input  wire logic [31:0]        return_pc_i,
    input  wire logic [31:0]        stack_ptr_i,
    input  wire logic               push_done_i,
    input  wire logic               push_err_i,
    input  wire logic               pref_done_i,
    input  wire logic               pref_err_i,
    input  wire logic               fetch_i,
    input  wire logic               flush_i,
    input  wire logic               loop_recirc_i,
    input  wire logic [15:0]        fetch_word_i,
    input  wire logic [1:0]         advance_i,
    output var  dbgtr_core_req_type core_req_o,
    output logic                    trap_o,
    output logic                    periph_rst_n_o,
    output logic                    resp_valid_o,
    output logic [16:0]             resp_o,
    output logic                    debug_mode_o,
    output logic                    busy_o,
    output logic                    fetch_indicator_n_o,
    output logic                    pipe_advance_indicator_n_o,
    output logic [2:0]              stage_valid_o
);
    localparam logic [9:0] RST_CNT = 10'(RST_CLKS);

    dbgtr_state_type    state, next_state;
    dbgtr_core_req_type req, next_req;
    logic [9:0]         cnt, next_cnt;
    logic [16:0]        resp, next_resp;
    logic               resp_v, next_resp_v;
    logic               trap, next_trap;
    logic               prst_n, next_prst_n;
    logic               dbg, next_dbg;
    logic               busy, next_busy;

    // command sequencer
    always_comb begin
        next_state  = state;
        next_req    = req;
        next_cnt    = cnt;
        next_resp   = resp;
        next_resp_v = 1'b0;
        next_trap   = 1'b0;
        next_prst_n = prst_n;
        next_dbg    = dbg;
        next_req.exit_debug = 1'b0;
        next_req.pc_load    = 1'b0;
        case (state)
            DBGTR_IDLE: begin
                if (cmd_valid_i && dbg) begin
                    case (cmd_word_i)
                        DBGTR_CMD_CALL: begin
                            next_req.push_req  = 1'b1;
                            next_req.push_data = return_pc_i;
                            next_req.push_addr = stack_ptr_i;
                            next_req.pc_value  = cmd_operand_i;
                            next_state = DBGTR_PUSH;
                        end
                        DBGTR_CMD_PRST: begin
                            next_prst_n = 1'b0;
                            next_cnt    = RST_CNT;
                            next_state  = DBGTR_PRST;
                        end
                        DBGTR_CMD_NULL: begin
                            next_resp   = DBGTR_RSP_DONE;
                            next_resp_v = 1'b1;
                        end
                        default: begin
                            // ill status still uses exactly one shift
                            next_resp   = DBGTR_RSP_ILL;
                            next_resp_v = 1'b1;
                        end
                    endcase
                end
            end
            DBGTR_PUSH: begin
                if (push_err_i) begin
                    next_req.push_req = 1'b0;
                    next_resp   = DBGTR_RSP_ERR;
                    next_resp_v = 1'b1;
                    next_state  = DBGTR_IDLE;
                end else if (push_done_i) begin
                    next_req.push_req   = 1'b0;
                    next_req.pc_load    = 1'b1;
                    next_req.exit_debug = 1'b1;
                    next_dbg   = 1'b0;
                    next_state = DBGTR_PREF;
                end
            end
            DBGTR_PREF: begin
                // debug is already left; a fault here is a normal trap
                if (pref_err_i) begin
                    next_trap  = 1'b1;
                    next_state = DBGTR_IDLE;
                end else if (pref_done_i) begin
                    next_state = DBGTR_IDLE;
                end
            end
            DBGTR_PRST: begin
                if (cnt == DBGTR_CNT_ONE) begin
                    next_prst_n = 1'b1;
                    next_cnt    = DBGTR_CNT_ZERO;
                    next_state  = DBGTR_RESP;
                end else begin
                    next_cnt = cnt - DBGTR_CNT_ONE;
                end
            end
            DBGTR_RESP: begin
                next_resp   = DBGTR_RSP_DONE;
                next_resp_v = 1'b1;
                next_state  = DBGTR_IDLE;
            end
            default: next_state = DBGTR_IDLE;
        endcase
        // registered so that busy_o comes straight from a flip-flop
        next_busy = (next_state != DBGTR_IDLE);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state  <= DBGTR_IDLE;
            req    <= '0;
            cnt    <= DBGTR_CNT_ZERO;
            resp   <= '0;
            resp_v <= 1'b0;
            trap   <= 1'b0;
            prst_n <= 1'b1;
            dbg    <= 1'b1;
            busy   <= 1'b0;
        end else begin
            state  <= next_state;
            req    <= next_req;
            cnt    <= next_cnt;
            resp   <= next_resp;
            resp_v <= next_resp_v;
            trap   <= next_trap;
            prst_n <= next_prst_n;
            dbg    <= next_dbg;
            busy   <= next_busy;
        end
    end

    // opcode tracking pins
    logic       fi_n, next_fi_n;
    logic       fi_hold, next_fi_hold;
    logic       pa_n, next_pa_n;
    logic       pa_hold, next_pa_hold;

    always_comb begin
        next_fi_n    = 1'b1;
        next_fi_hold = 1'b0;
        // no privilege input: user and supervisor fetches look alike
        if (fi_hold) begin
            next_fi_n = 1'b0;
        end else if (fetch_i && !loop_recirc_i) begin
            next_fi_n    = 1'b0;
            next_fi_hold = flush_i;
        end
        next_pa_n    = 1'b1;
        next_pa_hold = 1'b0;
        // driven from clk so it moves with the system clock only
        if (pa_hold) begin
            next_pa_n = 1'b0;
        end else if (advance_i == DBGTR_ADV_ONE) begin
            next_pa_n = 1'b0;
        end else if (advance_i == DBGTR_ADV_TWO) begin
            next_pa_n    = 1'b0;
            next_pa_hold = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fi_n    <= 1'b1;
            fi_hold <= 1'b0;
            pa_n    <= 1'b1;
            pa_hold <= 1'b0;
        end else begin
            fi_n    <= next_fi_n;
            fi_hold <= next_fi_hold;
            pa_n    <= next_pa_n;
            pa_hold <= next_pa_hold;
        end
    end

    // three-stage pipeline model
    dbgtr_stage_type sa, sb, sc;
    logic            a_load, a_clr, b_load, b_clr, c_load;
    logic            adv_any, adv_full;

    assign adv_any  = (advance_i != 2'h0);
    assign adv_full = (advance_i == DBGTR_ADV_TWO);
    // receiver set, supplier cleared; words ripple into an empty stage b, while stage c loads only on a full advance
    // a flush must not let an old word slip past the clear
    assign c_load = adv_full && sb.valid && !flush_i;
    assign b_load = (adv_any || !sb.valid) && sa.valid && !flush_i;
    assign b_clr  = adv_any || flush_i;
    assign a_load = fetch_i && !loop_recirc_i;
    assign a_clr  = b_load || flush_i;

    dbgtr_stage u_stage_a (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (a_load),
        .clear_i (a_clr),
        .word_i  (fetch_word_i),
        .stage_o (sa)
    );
    dbgtr_stage u_stage_b (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (b_load),
        .clear_i (b_clr),
        .word_i  (sa.word),
        .stage_o (sb)
    );
    dbgtr_stage u_stage_c (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (c_load),
        .clear_i (flush_i),
        .word_i  (sb.word),
        .stage_o (sc)
    );

    assign core_req_o                 = req;
    assign trap_o                     = trap;
    assign periph_rst_n_o             = prst_n;
    assign resp_valid_o               = resp_v;
    assign resp_o                     = resp;
    assign debug_mode_o               = dbg;
    assign busy_o                     = busy;
    assign fetch_indicator_n_o        = fi_n;
    assign pipe_advance_indicator_n_o = pa_n;
    assign stage_valid_o              = {sc.valid, sb.valid, sa.valid};

    property p_rst_len;
        @(posedge clk_i) disable iff (!rst_n_i)
        $fell(prst_n) |-> !prst_n [*8];
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("reset output too short");

    property p_rst_resp;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(prst_n) |=> resp_v && resp == DBGTR_RSP_DONE;
    endproperty
    a_rst_resp: assert property (p_rst_resp)
        else $error("no completion after peripheral reset");

    property p_null;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == DBGTR_IDLE && dbg && cmd_valid_i
            && cmd_word_i == DBGTR_CMD_NULL
            |=> resp_v && resp == DBGTR_RSP_DONE;
    endproperty
    a_null: assert property (p_null)
        else $error("null command lacks completion");

    property p_ill;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == DBGTR_IDLE && dbg && cmd_valid_i
            && cmd_word_i != DBGTR_CMD_NULL && cmd_word_i != DBGTR_CMD_PRST
            && cmd_word_i != DBGTR_CMD_CALL
            |=> resp_v && resp == DBGTR_RSP_ILL && state == DBGTR_IDLE;
    endproperty
    a_ill: assert property (p_ill)
        else $error("unassigned command not answered command_response_a");

    property p_push_err;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == DBGTR_PUSH && push_err_i
            |=> dbg && resp == DBGTR_RSP_ERR && resp_v;
    endproperty
    a_push_err: assert property (p_push_err)
        else $error("push error must stay in debug with error status");

    property p_call_exit;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == DBGTR_PUSH && push_done_i && !push_err_i
            |=> !dbg && req.pc_load && req.pc_value == $past(req.pc_value);
    endproperty
    a_call_exit: assert property (p_call_exit)
        else $error("call did not load counter and exit");

    property p_pref_trap;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == DBGTR_PREF && pref_err_i |=> trap && !dbg;
    endproperty
    a_pref_trap: assert property (p_pref_trap)
        else $error("prefetch error not trapped");

    property p_flush_fi;
        @(posedge clk_i) disable iff (!rst_n_i)
        fetch_i && flush_i && !loop_recirc_i && !fi_hold
            |=> !fi_n ##1 !fi_n;
    endproperty
    a_flush_fi: assert property (p_flush_fi)
        else $error("flush fetch indicator not two clocks");

    property p_loop;
        @(posedge clk_i) disable iff (!rst_n_i)
        loop_recirc_i && !fi_hold |=> fi_n;
    endproperty
    a_loop: assert property (p_loop)
        else $error("fetch indicated while recirculating");

    property p_adv_two;
        @(posedge clk_i) disable iff (!rst_n_i)
        advance_i == DBGTR_ADV_TWO && !pa_hold |=> !pa_n ##1 !pa_n;
    endproperty
    a_adv_two: assert property (p_adv_two)
        else $error("full advance not two clocks");

    property p_adv_c;
        @(posedge clk_i) disable iff (!rst_n_i)
        adv_full && sb.valid && !flush_i
            |=> sc.valid && sc.word == $past(sb.word);
    endproperty
    a_adv_c: assert property (p_adv_c)
        else $error("execute stage not loaded on full advance");
endmodule
`default_nettype wire

// ==== dv/dbgtr_far_model.sv ====
// far side: core bus that ends pushes and first prefetches, plus a trace
// sampler that measures how long each indicator stays low
// assumes the bench sets the fail and slow controls before each command
`timescale 1ns/1ps
`default_nettype none
module dbgtr_far_model
    import dbgtr_pkg::*;
(
    input  wire logic               clk_i,
    input  wire dbgtr_core_req_type core_req_i,
    input  wire logic               fail_push_i,
    input  wire logic               fail_pref_i,
    input  wire logic               slow_i,
    input  wire logic               fetch_indicator_n_i,
    input  wire logic               pipe_advance_indicator_n_i,
    output logic                    push_done_o,
    output logic                    push_err_o,
    output logic                    pref_done_o,
    output logic                    pref_err_o,
    output var int                  fetch_run_o,
    output var int                  fetch_cnt_o,
    output var int                  pipe_run_o
);
    int   wait_cnt  = 0;
    int   fetch_len = 0;
    int   pipe_len  = 0;
    logic pref_due  = 1'b0;

    initial begin
        {push_done_o, push_err_o, pref_done_o, pref_err_o} = 4'h0;
        {fetch_run_o, fetch_cnt_o, pipe_run_o} = '0;
    end

    always @(posedge clk_i) begin
        {push_done_o, push_err_o, pref_done_o, pref_err_o} <= 4'h0;
        // the last answer is still seen this edge, so never answer twice
        if (core_req_i.push_req && !push_done_o && !push_err_o) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == (slow_i ? 5 : 0)) begin
                push_err_o  <= fail_push_i;
                push_done_o <= !fail_push_i;
                wait_cnt    <= 0;
            end
        end
        if (pref_due) begin
            pref_err_o  <= fail_pref_i;
            pref_done_o <= !fail_pref_i;
        end
        pref_due <= core_req_i.pc_load;
        // fetch indicator sampled on rising edges
        if (!fetch_indicator_n_i) begin
            fetch_len <= fetch_len + 1;
        end else if (fetch_len != 0) begin
            fetch_run_o <= fetch_len;
            fetch_cnt_o <= fetch_cnt_o + 1;
            fetch_len   <= 0;
        end
    end

    // pipe advance sampled on falling edges; one run may hold two indications
    always @(negedge clk_i) begin
        if (!pipe_advance_indicator_n_i) begin
            pipe_len <= pipe_len + 1;
        end else if (pipe_len != 0) begin
            pipe_run_o <= pipe_len;
            pipe_len   <= 0;
        end
    end
endmodule
`default_nettype wire

// ==== dv/dbgtr_tb.sv ====
// self-checking bench for the debug command tail and opcode tracking
// assumes the far model answers core requests; full reset length is used
`timescale 1ns/1ps
`default_nettype none
module tb
    import dbgtr_pkg::*;
;
    localparam int RST = DBGTR_RST_CLKS;
    localparam int TMO = 20000;
    logic               clk_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic               cmd_valid_i = 1'b0;
    logic [15:0]        cmd_word_i = 16'h0000;
    logic [31:0]        cmd_operand_i = 32'h0;
    logic [31:0]        return_pc_i = 32'h0000_1234;
    logic [31:0]        stack_ptr_i = 32'h0000_3FF0;
    logic               push_done_i, push_err_i, pref_done_i, pref_err_i;
    logic               fetch_i = 1'b0;
    logic               flush_i = 1'b0;
    logic               loop_recirc_i = 1'b0;
    logic [15:0]        fetch_word_i = 16'h0000;
    logic [1:0]         advance_i = 2'h0;
    dbgtr_core_req_type core_req_o;
    logic               trap_o, periph_rst_n_o, resp_valid_o, debug_mode_o;
    logic [16:0]        resp_o;
    logic               busy_o, fetch_indicator_n_o;
    logic               pipe_advance_indicator_n_o;
    logic [2:0]         stage_valid_o;
    logic               fail_push = 1'b0;
    logic               fail_pref = 1'b0;
    logic               slow = 1'b0;
    int                 fetch_run, fetch_cnt, pipe_run;
    int                 n_fail = 0;
    int                 comparisons = 0;
    int                 cycles = 0;

    dbgtr_top #(.RST_CLKS(RST)) dut (
        .clk_i, .rst_n_i, .cmd_valid_i, .cmd_word_i, .cmd_operand_i,
        .return_pc_i, .stack_ptr_i, .push_done_i, .push_err_i,
        .pref_done_i, .pref_err_i, .fetch_i, .flush_i, .loop_recirc_i,
        .fetch_word_i, .advance_i, .core_req_o, .trap_o, .periph_rst_n_o,
        .resp_valid_o, .resp_o, .debug_mode_o, .busy_o,
        .fetch_indicator_n_o, .pipe_advance_indicator_n_o, .stage_valid_o
    );

    dbgtr_far_model far (
        .clk_i(clk_i), .core_req_i(core_req_o), .fail_push_i(fail_push),
        .fail_pref_i(fail_pref), .slow_i(slow),
        .fetch_indicator_n_i(fetch_indicator_n_o),
        .pipe_advance_indicator_n_i(pipe_advance_indicator_n_o),
        .push_done_o(push_done_i), .push_err_o(push_err_i),
        .pref_done_o(pref_done_i), .pref_err_o(pref_err_i),
        .fetch_run_o(fetch_run), .fetch_cnt_o(fetch_cnt),
        .pipe_run_o(pipe_run)
    );

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == TMO) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
    endtask

    // ends 1 ns after the edge that takes the command
    task automatic send_cmd(input logic [15:0] w, input logic [31:0] op);
        @(posedge clk_i);
        cmd_valid_i   <= 1'b1;
        cmd_word_i    <= w;
        cmd_operand_i <= op;
        @(posedge clk_i);
        cmd_valid_i   <= 1'b0;
        #1;
    endtask

    task automatic wait_on(input int sel, output bit hit);
        hit = 0;
        for (int i = 0; i < 60 && !hit; i++) begin
            @(posedge clk_i);
            #1;
            hit = (sel == 0) ? resp_valid_o === 1'b1 :
                  (sel == 1) ? core_req_o.exit_debug === 1'b1 :
                  trap_o === 1'b1;
        end
    endtask

    task automatic pulse_fetch(input logic fl, input logic lp);
        @(posedge clk_i);
        fetch_i       <= 1'b1;
        flush_i       <= fl;
        loop_recirc_i <= lp;
        fetch_word_i  <= fetch_word_i + 16'h0001;
        @(posedge clk_i);
        fetch_i       <= 1'b0;
        flush_i       <= 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
    endtask

    task automatic advance(input logic [1:0] a, input logic [1:0] b);
        @(posedge clk_i);
        advance_i <= a;
        @(posedge clk_i);
        advance_i <= b;
        @(posedge clk_i);
        advance_i <= 2'h0;
        repeat (6) @(posedge clk_i);
        #1;
    endtask

    task automatic t_commands();
        logic [15:0] ill [3] = '{16'h0401, 16'h0801, 16'hFFFF};
        send_cmd(DBGTR_CMD_NULL, 32'h0);
        check("null valid", resp_valid_o, 1);
        check("null resp", resp_o, DBGTR_RSP_DONE);
        foreach (ill[i]) begin
            send_cmd(ill[i], 32'h0);
            check("ill valid", resp_valid_o, 1);
            check("ill resp", resp_o, DBGTR_RSP_ILL);
        end
        check("ill mode", debug_mode_o, 1);
    endtask

    task automatic t_periph_reset();
        int lows;
        bit hit;
        lows = 0;
        hit = 0;
        send_cmd(DBGTR_CMD_PRST, 32'h0);
        for (int i = 0; i < 4 * RST && !hit; i++) begin
            if (periph_rst_n_o === 1'b0) lows++;
            hit = resp_valid_o === 1'b1;
            @(posedge clk_i);
            #1;
        end
        check("rst length", lows, RST);
        check("rst core", debug_mode_o, 1);
        check("rst resp", resp_o, DBGTR_RSP_DONE);
    endtask

    task automatic t_call();
        bit hit;
        @(posedge clk_i);
        fail_push <= 1'b1;
        send_cmd(DBGTR_CMD_CALL, 32'h0000_4000);
        check("push req", core_req_o.push_req, 1);
        check("push addr", core_req_o.push_addr, 32'h0000_3FF0);
        check("push data", core_req_o.push_data, 32'h0000_1234);
        check("busy call", busy_o, 1);
        wait_on(0, hit);
        check("err resp", resp_o, DBGTR_RSP_ERR);
        check("err mode", debug_mode_o, 1);
        check("busy done", busy_o, 0);
        @(posedge clk_i);
        fail_push <= 1'b0;
        fail_pref <= 1'b1;
        slow      <= 1'b1;
        send_cmd(DBGTR_CMD_CALL, 32'h0000_4000);
        wait_on(1, hit);
        check("exit seen", hit, 1);
        check("pc load", core_req_o.pc_load, 1);
        check("pc value", core_req_o.pc_value, 32'h0000_4000);
        check("exit mode", debug_mode_o, 0);
        wait_on(2, hit);
        check("trap", hit, 1);
        send_cmd(DBGTR_CMD_NULL, 32'h0);
        check("refused", resp_valid_o, 0);
    endtask

    task automatic t_fetch();
        int base;
        pulse_fetch(1'b0, 1'b0);
        check("fetch run", fetch_run, 1);
        pulse_fetch(1'b1, 1'b0);
        check("flush run", fetch_run, 2);
        base = fetch_cnt;
        pulse_fetch(1'b0, 1'b1);
        check("loop fetch", fetch_cnt, base);
        pulse_fetch(1'b0, 1'b0);
        check("after loop", fetch_cnt, base + 1);
    endtask

    task automatic t_pipe();
        do_reset();
        check("stages rst", stage_valid_o, 3'b000);
        pulse_fetch(1'b0, 1'b0);
        check("one word", stage_valid_o, 3'b010);
        pulse_fetch(1'b0, 1'b0);
        check("two words", stage_valid_o, 3'b011);
        advance(2'h1, 2'h0);
        check("adv one run", pipe_run, 1);
        check("adv one st", stage_valid_o, 3'b010);
        advance(2'h2, 2'h0);
        check("adv two run", pipe_run, 2);
        check("adv two st", stage_valid_o, 3'b100);
        advance(2'h1, 2'h2);
        check("merged run", pipe_run, 3);
    endtask

    initial begin
        do_reset();
        t_commands();
        t_periph_reset();
        t_fetch();
        t_call();
        t_pipe();
        give_verdict();
    end
endmodule
`default_nettype wire
